/* File: core/bkhc_top.sv */
// breakpoint trigger matching and halt control for the processor core
// assumes core strobes are on mclk; the breakpoint pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "bkhc_cfg.svh"

module bkhc_top
(
   input  wire logic        mclk,
   input  wire logic        srst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // core observation
   input  wire logic [31:0] data_bus,
   input  wire logic [31:0] addr_bus,
   input  wire logic        acc_valid,
   input  wire logic [31:0] pc,
   input  wire logic        pc_valid,
   input  wire logic        sample_point,
   input  wire logic        fault_on_fault,
   input  wire logic        suspend_exec,
   input  wire logic        sleep_exec,
   input  wire logic        user_mode,
   input  wire logic        resume_command,
   input  wire logic        breakpoint_request_n,
   // outputs toward core and pins
   output logic             core_halted,
   output logic             core_stopped,
   output logic             priv_violation,
   output logic             debug_irq,
   output logic             trig_report,
   output logic             reset_exc_start,
   output logic             resume_pulse,
   output logic      [1:0]  resume_kind,
   output logic      [3:0]  processor_status_outputs,
   output logic      [3:0]  debug_data_outputs
);
   // registers
   logic [31:0] trigger_definition;
   logic [31:0] address_bound_low;
   logic [31:0] address_bound_high;
   logic [31:0] pc_breakpoint_value;
   logic [31:0] pc_breakpoint_mask;
   logic [31:0] data_breakpoint_value;
   logic [31:0] pc_load;
   logic        user_stop_permit;
   logic        shadow_debug_select;
   logic        pc_loaded;
   logic [3:0]  halt_src;
   logic        level1_done;
   logic        brk_pending;
   logic        pin_pending;
   logic [4:0]  rst_cnt;
   logic        pin_sync1;
   logic        pin_sync2;
   bkhc_pkg::bkhc_state_t state;
   bkhc_pkg::bkhc_state_t next_state;

   // pin passes two flops before any logic looks at it
   always_ff @(posedge mclk)
   begin
      pin_sync1 <= ~breakpoint_request_n;
      pin_sync2 <= pin_sync1;
   end
   wire pin_req = pin_sync2;

   // two trigger levels, lower half first level, upper half second
   wire hit1;
   wire hit2;
   bkhc_level u_lvl1
   (
      .cfg       (trigger_definition[15:0]),
      .data_bus  (data_bus),
      .data_val  (data_breakpoint_value),
      .addr_bus  (addr_bus),
      .addr_lo   (address_bound_low),
      .addr_hi   (address_bound_high),
      .pc        (pc),
      .pc_val    (pc_breakpoint_value),
      .pc_mask   (pc_breakpoint_mask),
      .acc_valid (acc_valid),
      .pc_valid  (pc_valid),
      .hit       (hit1)
   );
   bkhc_level u_lvl2
   (
      .cfg       (trigger_definition[31:16]),
      .data_bus  (data_bus),
      .data_val  (data_breakpoint_value),
      .addr_bus  (addr_bus),
      .addr_lo   (address_bound_low),
      .addr_hi   (address_bound_high),
      .pc        (pc),
      .pc_val    (pc_breakpoint_value),
      .pc_mask   (pc_breakpoint_mask),
      .acc_valid (acc_valid),
      .pc_valid  (pc_valid),
      .hit       (hit2)
   );

   // second level only counts once the first has fired; with level two
   // disabled the first level completes the trigger on its own
   wire lvl2_on  = trigger_definition[16 + `BKHC_F_GLB_EN];
   wire trig_l1  = hit1 & ~lvl2_on;
   wire trig_l2  = hit2 & level1_done;
   wire trig     = trig_l1 | trig_l2;
   wire [1:0] resp = trig_l2 ? trigger_definition[31:30]
                             : trigger_definition[15:14];
   wire trig_halt = trig & (resp == 2'b01);
   wire trig_irq  = trig & (resp == 2'b10);
   wire trig_wr   = reg_wr & (reg_addr == `BKHC_OFS_TRIG);

   // register decode
   wire sel_ctrl  = reg_wr & (reg_addr == `BKHC_OFS_CTRL);
   wire sel_pcld  = reg_wr & (reg_addr == `BKHC_OFS_PC_LOAD);
   wire halted_any = (state == bkhc_pkg::BKHC_HALTED)
                   | (state == bkhc_pkg::BKHC_RST_HALT);
   wire in_run    = state == bkhc_pkg::BKHC_RUN;

   // suspend in user mode needs permission, else privilege fault
   wire susp_ok   = suspend_exec & in_run & (~user_mode | user_stop_permit);
   wire susp_bad  = suspend_exec & in_run & user_mode & ~user_stop_permit;
   wire fof       = fault_on_fault & in_run;
   wire brk_take  = (brk_pending | trig_halt) & sample_point & in_run;
   wire pin_take  = (pin_pending | pin_req) & sample_point & in_run;
   wire pin_early = (state == bkhc_pkg::BKHC_RST_WAIT)
                  & (rst_cnt < `BKHC_RST_PINWIN) & pin_req;
   wire pin_sleep = (state == bkhc_pkg::BKHC_SLEEP) & pin_req;

   // highest-priority cause of this halt
   wire [3:0] next_src = fof       ? `BKHC_SRC_FAULT
                       : brk_take  ? `BKHC_SRC_BRKPT
                       : susp_ok   ? `BKHC_SRC_SUSPEND
                       : pin_sleep ? `BKHC_SRC_SLEEP
                       : (pin_take | pin_early) ? `BKHC_SRC_PIN
                       : halt_src;
   wire halt_now = fof | brk_take | susp_ok | pin_take;

   // next core state
   always_comb
   begin
      next_state = state;
      unique case (state)
         bkhc_pkg::BKHC_RST_WAIT:
         begin
            if (pin_early)
               next_state = bkhc_pkg::BKHC_RST_HALT;
            else if (rst_cnt == `BKHC_RST_WAIT - 5'd1)
               next_state = bkhc_pkg::BKHC_RUN;
         end
         bkhc_pkg::BKHC_RUN:
         begin
            if (halt_now)
               next_state = bkhc_pkg::BKHC_HALTED;
            else if (sleep_exec)
               next_state = bkhc_pkg::BKHC_SLEEP;
         end
         bkhc_pkg::BKHC_SLEEP:
            if (pin_sleep)
               next_state = bkhc_pkg::BKHC_HALTED;
         bkhc_pkg::BKHC_HALTED:
            if (resume_command)
               next_state = bkhc_pkg::BKHC_RUN;
         bkhc_pkg::BKHC_RST_HALT:
            if (resume_command)
               next_state = bkhc_pkg::BKHC_RUN;
         default:
            next_state = bkhc_pkg::BKHC_RST_WAIT;
      endcase
   end

   // state, reset counter and pending flags; an event served at its take edge does not pend again
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state       <= bkhc_pkg::BKHC_RST_WAIT;
         rst_cnt     <= 5'd0;
         brk_pending <= 1'b0;
         pin_pending <= 1'b0;
         level1_done <= 1'b0;
         halt_src    <= `BKHC_SRC_NONE;
      end
      else
      begin
         state       <= next_state;
         rst_cnt     <= (state == bkhc_pkg::BKHC_RST_WAIT) ? rst_cnt + 5'd1 : rst_cnt;
         brk_pending <= (trig_halt | brk_pending) & ~brk_take;
         pin_pending <= ((pin_req & in_run) | pin_pending) & ~pin_take;
         level1_done <= (hit1 & lvl2_on) | (level1_done & ~trig_l2 & ~trig_wr);
         halt_src    <= next_src;
      end
   end

   // software-written registers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         trigger_definition    <= `BKHC_RST_TRIG;
         address_bound_low     <= `BKHC_RST_MASK;
         address_bound_high    <= `BKHC_RST_MASK;
         pc_breakpoint_value   <= `BKHC_RST_MASK;
         pc_breakpoint_mask    <= `BKHC_RST_MASK;
         data_breakpoint_value <= `BKHC_RST_MASK;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `BKHC_OFS_TRIG:     trigger_definition    <= reg_wdata;
            `BKHC_OFS_ADDR_LO:  address_bound_low     <= reg_wdata;
            `BKHC_OFS_ADDR_HI:  address_bound_high    <= reg_wdata;
            `BKHC_OFS_PC_VAL:   pc_breakpoint_value   <= reg_wdata;
            `BKHC_OFS_PC_MASK:  pc_breakpoint_mask    <= reg_wdata;
            `BKHC_OFS_DATA_VAL: data_breakpoint_value <= reg_wdata;
            default:            ;
         endcase
      end
   end

   // control bits and the program counter loaded while halted
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         user_stop_permit    <= 1'b0;
         shadow_debug_select <= 1'b0;
         pc_load             <= 32'h0000_0000;
         pc_loaded           <= 1'b0;
      end
      else
      begin
         if (sel_ctrl)
            user_stop_permit <= reg_wdata[`BKHC_CTL_UPERMIT];
         if (sel_ctrl & (state == bkhc_pkg::BKHC_RST_HALT))
            shadow_debug_select <= reg_wdata[`BKHC_CTL_SHADOW];
         if (sel_pcld & halted_any)
            pc_load <= reg_wdata;
         pc_loaded <= (sel_pcld & halted_any) | (pc_loaded & ~resume_command);
      end
   end

   // read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (reg_addr)
         `BKHC_OFS_TRIG:      rd_mux = trigger_definition;
         `BKHC_OFS_ADDR_LO:   rd_mux = address_bound_low;
         `BKHC_OFS_ADDR_HI:   rd_mux = address_bound_high;
         `BKHC_OFS_PC_VAL:    rd_mux = pc_breakpoint_value;
         `BKHC_OFS_PC_MASK:   rd_mux = pc_breakpoint_mask;
         `BKHC_OFS_DATA_VAL:  rd_mux = data_breakpoint_value;
         `BKHC_OFS_STATUS:    rd_mux = {4'h0, halt_src, 20'h0_0000, state, 1'b0};
         `BKHC_OFS_CTRL:      rd_mux = {30'h0, shadow_debug_select, user_stop_permit};
         `BKHC_OFS_PC_LOAD:   rd_mux = pc_load;
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   // resume kind: after reset halt jump to loaded pc or run reset handling
   wire [1:0] go_kind = (state != bkhc_pkg::BKHC_RST_HALT) ? bkhc_pkg::BKHC_GO_NEXT
                      : pc_loaded ? bkhc_pkg::BKHC_GO_PC
                      : bkhc_pkg::BKHC_GO_RESET;
   wire going   = halted_any & resume_command;
   wire rst_go  = ((state == bkhc_pkg::BKHC_RST_WAIT)
                  & (next_state == bkhc_pkg::BKHC_RUN))
                | (going & ~pc_loaded & (state == bkhc_pkg::BKHC_RST_HALT));

   // registered outputs
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         reg_rdata                <= 32'h0000_0000;
         core_halted              <= 1'b0;
         core_stopped             <= 1'b0;
         priv_violation           <= 1'b0;
         debug_irq                <= 1'b0;
         trig_report              <= 1'b0;
         reset_exc_start          <= 1'b0;
         resume_pulse             <= 1'b0;
         resume_kind              <= bkhc_pkg::BKHC_GO_NEXT;
         processor_status_outputs <= `BKHC_PST_RUN;
         debug_data_outputs       <= 4'h0;
      end
      else
      begin
         reg_rdata       <= reg_rd ? rd_mux : 32'h0000_0000;
         core_halted     <= (next_state == bkhc_pkg::BKHC_HALTED)
                          | (next_state == bkhc_pkg::BKHC_RST_HALT);
         core_stopped    <= next_state == bkhc_pkg::BKHC_SLEEP;
         priv_violation  <= susp_bad;
         debug_irq       <= trig_irq;
         trig_report     <= trig;
         reset_exc_start <= rst_go;
         resume_pulse    <= going;
         resume_kind     <= going ? go_kind : resume_kind;
         processor_status_outputs <= ((next_state == bkhc_pkg::BKHC_HALTED)
                                    | (next_state == bkhc_pkg::BKHC_RST_HALT))
                                    ? `BKHC_PST_HALT : `BKHC_PST_RUN;
         debug_data_outputs <= trig ? {trig_l2, trig_l1, resp} : 4'h0;
      end
   end

endmodule // bkhc_top
`default_nettype wire

/* File: include/bkhc_cfg.svh */
// constants for the breakpoint trigger and halt control block
// assumes a single 25 MHz processor clock and a synchronous reset
`ifndef BKHC_CFG_SVH
`define BKHC_CFG_SVH

// register offsets (byte addresses, one word each)
`define BKHC_OFS_TRIG      8'h00
`define BKHC_OFS_ADDR_LO   8'h04
`define BKHC_OFS_ADDR_HI   8'h08
`define BKHC_OFS_PC_VAL    8'h0C
`define BKHC_OFS_PC_MASK   8'h10
`define BKHC_OFS_DATA_VAL  8'h14
`define BKHC_OFS_DATA_MASK 8'h18
`define BKHC_OFS_STATUS    8'h1C
`define BKHC_OFS_CTRL      8'h20
`define BKHC_OFS_PC_LOAD   8'h24

// trigger field positions inside one 16-bit level
`define BKHC_F_RESP_HI   15
`define BKHC_F_RESP_LO   14
`define BKHC_F_GLB_EN    13
`define BKHC_F_FULL      12
`define BKHC_F_LOW_HALF  11
`define BKHC_F_HIGH_HALF 10
`define BKHC_F_BYTE0     9
`define BKHC_F_BYTE1     8
`define BKHC_F_BYTE2     7
`define BKHC_F_BYTE3     6
`define BKHC_F_DINV      5
`define BKHC_F_A_OUT     4
`define BKHC_F_A_IN      3
`define BKHC_F_A_LOW     2
`define BKHC_F_PC_EN     1
`define BKHC_F_PC_INV    0

// status and control register fields
`define BKHC_ST_SRC_HI   27
`define BKHC_ST_SRC_LO   24
`define BKHC_CTL_UPERMIT 0
`define BKHC_CTL_SHADOW  1

// reset values
`define BKHC_RST_TRIG    32'h0000_0000
`define BKHC_RST_MASK    32'h0000_0000

// halt-source and processor-status codes
`define BKHC_SRC_NONE    4'h0
`define BKHC_SRC_FAULT   4'h1
`define BKHC_SRC_BRKPT   4'h2
`define BKHC_SRC_SUSPEND 4'h3
`define BKHC_SRC_PIN     4'h4
`define BKHC_SRC_SLEEP   4'h5
`define BKHC_PST_HALT    4'hF
`define BKHC_PST_RUN     4'h0

// timing counts after reset release
`define BKHC_RST_WAIT    5'd16
`define BKHC_RST_PINWIN  5'd8

`endif

/* File: include/bkhc_pkg.sv */
// types for the breakpoint trigger and halt control block
// shared by the top module and its self-checking bench
package bkhc_pkg;

   // core state as seen by the halt controller
   typedef enum logic [2:0]
   {
      BKHC_RST_WAIT = 3'b000,
      BKHC_RUN      = 3'b001,
      BKHC_HALTED   = 3'b010,
      BKHC_SLEEP    = 3'b011,
      BKHC_RST_HALT = 3'b100
   } bkhc_state_t;

   // what the core does on leaving the halt
   typedef enum logic [1:0]
   {
      BKHC_GO_NEXT  = 2'b00,
      BKHC_GO_PC    = 2'b01,
      BKHC_GO_RESET = 2'b10
   } bkhc_go_t;

endpackage

/* File: core/bkhc_level.sv */
// one trigger level: data, address and pc conditions from a 16-bit field
// assumes bus values arrive on the same clock, already qualified by valid
`timescale 1ns/1ps
`default_nettype none
`include "bkhc_cfg.svh"

module bkhc_level
(
   input  wire logic [15:0] cfg,
   input  wire logic [31:0] data_bus,
   input  wire logic [31:0] data_val,
   input  wire logic [31:0] addr_bus,
   input  wire logic [31:0] addr_lo,
   input  wire logic [31:0] addr_hi,
   input  wire logic [31:0] pc,
   input  wire logic [31:0] pc_val,
   input  wire logic [31:0] pc_mask,
   input  wire logic        acc_valid,
   input  wire logic        pc_valid,
   output logic             hit
);
   // per-lane equality; lane 0 is the lowest byte of the low half
   wire [3:0] lane_eq;
   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_lane
         assign lane_eq[i] = data_bus[8*i +: 8] == data_val[8*i +: 8];
      end
   endgenerate

   wire [6:0] lane_en  = cfg[`BKHC_F_FULL:`BKHC_F_BYTE3];
   wire       data_on  = |lane_en;
   wire       dinv     = cfg[`BKHC_F_DINV];
   wire       m_full   = cfg[`BKHC_F_FULL] & ((&lane_eq) ^ dinv);
   wire       m_lowh   = cfg[`BKHC_F_LOW_HALF] & ((&lane_eq[1:0]) ^ dinv);
   wire       m_highh  = cfg[`BKHC_F_HIGH_HALF] & ((&lane_eq[3:2]) ^ dinv);
   wire       m_b0     = cfg[`BKHC_F_BYTE0] & (lane_eq[0] ^ dinv);
   wire       m_b1     = cfg[`BKHC_F_BYTE1] & (lane_eq[1] ^ dinv);
   wire       m_b2     = cfg[`BKHC_F_BYTE2] & (lane_eq[2] ^ dinv);
   wire       m_b3     = cfg[`BKHC_F_BYTE3] & (lane_eq[3] ^ dinv);
   wire       data_ok  = m_full | m_lowh | m_highh | m_b0 | m_b1 | m_b2 | m_b3;

   // address conditions; inclusive bounds
   wire       in_rng   = (addr_bus >= addr_lo) && (addr_bus <= addr_hi);
   wire [2:0] aen      = cfg[`BKHC_F_A_OUT:`BKHC_F_A_LOW];
   wire       addr_on  = |aen;
   wire       addr_ok  = (aen[2] & ~in_rng)
                       | (aen[1] & in_rng)
                       | (aen[0] & (addr_bus == addr_lo));

   // pc region: set mask bits ignore the matching value bits
   wire       pc_in    = ((pc ^ pc_val) & ~pc_mask) == 32'h0000_0000;
   wire       pc_on    = cfg[`BKHC_F_PC_EN];
   wire       pc_ok    = pc_in ^ cfg[`BKHC_F_PC_INV];

   // enabled conditions must all hold; at least one must be enabled
   wire       any_on   = data_on | addr_on | pc_on;
   wire       acc_part = (~data_on | data_ok) & (~addr_on | addr_ok);
   wire       acc_need = data_on | addr_on;
   assign hit = cfg[`BKHC_F_GLB_EN] & any_on
              & (~acc_need | (acc_valid & acc_part))
              & (~pc_on | (pc_valid & pc_ok));

endmodule // bkhc_level
`default_nettype wire

/* File: test/bkhc_assertions.sv */
// checker for the breakpoint trigger and halt control top ports
// assumes one mclk domain with synchronous active-high srst
`timescale 1ns/1ps
`default_nettype none

module bkhc_assertions
(
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic       fault_on_fault,
   input wire logic       suspend_exec,
   input wire logic       sample_point,
   input wire logic       user_mode,
   input wire logic       resume_command,
   input wire logic       breakpoint_request_n,
   input wire logic       core_halted,
   input wire logic       core_stopped,
   input wire logic       priv_violation,
   input wire logic       debug_irq,
   input wire logic       trig_report,
   input wire logic       reset_exc_start,
   input wire logic       resume_pulse,
   input wire logic [3:0] processor_status_outputs,
   input wire logic [3:0] debug_data_outputs
);
   logic ran;
   wire  idle_run;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // core counts as running only after reset processing has started
   always_ff @(posedge mclk)
      if (srst)
         ran <= 1'b0;
      else if (reset_exc_start)
         ran <= 1'b1;
   assign idle_run = ran && !core_halted && !core_stopped;

   fault_halt_a: assert property
      (idle_run && fault_on_fault |=> core_halted && processor_status_outputs == 4'hF)
      else $error("fault did not halt");
   pst_code_a: assert property
      (processor_status_outputs == (core_halted ? 4'hF : 4'h0))
      else $error("status code wrong");
   reset_wait_a: assert property
      ($fell(srst) && breakpoint_request_n |-> !reset_exc_start [*8]
         ##1 !reset_exc_start [*8] ##1 reset_exc_start)
      else $error("reset wait wrong");
   priv_cause_a: assert property
      (priv_violation |-> $past(suspend_exec) && $past(user_mode))
      else $error("stray privilege violation");
   resume_go_a: assert property
      (core_halted && resume_command |=> !core_halted && resume_pulse)
      else $error("resume not taken");
   resume_src_a: assert property
      (resume_pulse |-> $past(core_halted) && $past(resume_command))
      else $error("stray resume");
   defer_halt_a: assert property
      (ran && $rose(core_halted) && !$past(fault_on_fault) && !$past(suspend_exec)
         && !$past(core_stopped) |-> $past(sample_point))
      else $error("halt off sample point");
   sleep_pin_a: assert property
      (core_stopped && !breakpoint_request_n |-> ##[1:5] core_halted)
      else $error("pin did not end sleep");
   irq_resp_a: assert property
      (debug_irq |-> trig_report && debug_data_outputs[1:0] == 2'b10)
      else $error("interrupt response code wrong");

   // main scenarios reached
   cover property (core_halted && resume_command);
   cover property ($rose(core_stopped));
   cover property (debug_irq);
   cover property (priv_violation);
endmodule // bkhc_assertions

`default_nettype wire

/* File: test/bkhc_core_model.sv */
// core pipeline model: raises the per-instruction sample point
// assumes a fixed four-cycle instruction; silent while halted or asleep
`timescale 1ns/1ps
`default_nettype none

module bkhc_core_model
(
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic core_halted,
   input  wire logic core_stopped,
   output logic      sample_point
);
   logic [1:0] instr_cnt;

   // a stopped core executes nothing, so it never samples
   always_ff @(posedge mclk)
      if (srst || core_halted || core_stopped)
         instr_cnt <= 2'h0;
      else
         instr_cnt <= instr_cnt + 2'h1;
   assign sample_point = (instr_cnt == 2'h3) && !core_halted && !core_stopped;
endmodule // bkhc_core_model

`default_nettype wire

/* File: test/bkhc_top_tb_top.sv */
// self-checking bench for the breakpoint trigger and halt control block
// assumes the core model gives sample points; the bench drives all else
`timescale 1ns/1ps
`default_nettype none
`include "bkhc_cfg.svh"

module bkhc_top_tb_top;
   logic        mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, data_bus = 32'h0, addr_bus = 32'h0, pc = 32'h0;
   logic        acc_valid = 1'b0, pc_valid = 1'b0, fault_on_fault = 1'b0;
   logic        suspend_exec = 1'b0, sleep_exec = 1'b0, user_mode = 1'b0;
   logic        resume_command = 1'b0, breakpoint_request_n = 1'b1;
   logic        sample_point, core_halted, core_stopped, priv_violation, debug_irq;
   logic        trig_report, reset_exc_start, resume_pulse;
   logic [1:0]  resume_kind;
   logic [3:0]  processor_status_outputs, debug_data_outputs;
   logic [31:0] reg_rdata, v;
   logic        h, q;
   logic [3:0]  o;
   int          miscompares = 0, compares = 0;
   // {expected hit, level-one config, value on data, address and pc}
   localparam logic [48:0] tab [21] = '{
      49'h1_3000_12345678, 49'h0_1000_12345678,
      49'h0_3000_12345679, 49'h1_2800_FFFF5678,
      49'h0_2400_FFFF5678, 49'h1_2200_FFFFFF78,
      49'h1_2100_FFFF56FF, 49'h1_2080_FF34FFFF,
      49'h1_2040_12FFFFFF, 49'h1_3020_00000000,
      49'h0_3020_12345678, 49'h1_2008_000001FF,
      49'h0_2008_00000200, 49'h1_2010_00000200,
      49'h0_2010_00000150, 49'h1_2004_00000100,
      49'h0_2004_00000104, 49'h1_2002_00002008,
      49'h0_2002_00002010, 49'h1_2003_00002010,
      49'h0_2000_12345678};

   bkhc_top bkhc_top_i (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .data_bus, .addr_bus, .acc_valid, .pc, .pc_valid, .sample_point, .fault_on_fault,
      .suspend_exec, .sleep_exec, .user_mode, .resume_command, .breakpoint_request_n,
      .core_halted, .core_stopped, .priv_violation, .debug_irq, .trig_report,
      .reset_exc_start, .resume_pulse, .resume_kind, .processor_status_outputs,
      .debug_data_outputs);
   bkhc_core_model bkhc_core_model_i (.mclk, .srst, .core_halted, .core_stopped,
      .sample_point);

   // 25 MHz processor clock
   always #20 mclk = ~mclk;

   task automatic wrap_up;
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // one-cycle strobes: {sleep, resume, suspend, fault}
   task automatic pulse(input logic [3:0] m);
      @(posedge mclk);
      {sleep_exec, resume_command, suspend_exec, fault_on_fault} <= m;
      @(posedge mclk);
      {sleep_exec, resume_command, suspend_exec, fault_on_fault} <= 4'h0;
      #1;
   endtask

   // bounded wait for the halt, then status code and reported source
   task automatic halted(input logic [3:0] src);
      logic [31:0] s;
      for (int n = 0; core_halted !== 1'b1; n++)
      begin
         if (n == 40)
         begin
            miscompares++;
            wrap_up();
         end
         @(posedge mclk);
         #1;
      end
      chk("pst", 32'(processor_status_outputs), 32'hF);
      rd(`BKHC_OFS_STATUS, s);
      if (src != 4'h0)
         chk("source", 32'(s[27:24]), 32'(src));
   endtask

   task automatic resume(input logic [1:0] k);
      pulse(4'h4);
      chk("halted", 32'(core_halted), 32'h0);
      chk("resume", 32'(resume_pulse), 32'h1);
      if (k != 2'h3)
         chk("kind", 32'(resume_kind), 32'(k));
   endtask

   // pin level is applied with reset, so a low pin lands in the early window
   task automatic rst(input logic p);
      int n;
      {srst, breakpoint_request_n} <= {1'b1, p};
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      for (n = 0; p && reset_exc_start !== 1'b1 && n < 40; n++)
      begin
         @(posedge mclk);
         #1;
      end
      if (p)
         chk("rstwait", 32'(n), 32'h10);
   endtask

   // one qualified access; watch the responses for a few cycles
   task automatic acc(input logic [31:0] d);
      @(posedge mclk);
      {data_bus, addr_bus, pc, acc_valid, pc_valid} <= {d, d, d, 2'b11};
      @(posedge mclk);
      {acc_valid, pc_valid} <= 2'b00;
      {h, q} = 2'b00;
      o = 4'h0;
      repeat (6)
      begin
         #1;
         h |= trig_report;
         q |= debug_irq;
         o |= debug_data_outputs;
         @(posedge mclk);
      end
   endtask

   initial
   begin
      rst(1'b1);
      rd(`BKHC_OFS_TRIG, v);
      chk("trigrst", v, `BKHC_RST_TRIG);
      rd(8'h18, v);
      chk("unmapped", v, 32'h0);
      // halt right after reset, with and without a loaded pc
      rst(1'b0);
      halted(4'h0);
      breakpoint_request_n <= 1'b1;
      wr(`BKHC_OFS_CTRL, 32'h2);
      rd(`BKHC_OFS_CTRL, v);
      chk("shadow", v, 32'h2);
      wr(`BKHC_OFS_PC_LOAD, 32'h0000_4000);
      resume(bkhc_pkg::BKHC_GO_PC);
      rst(1'b0);
      halted(4'h0);
      breakpoint_request_n <= 1'b1;
      repeat (16) @(posedge mclk);
      resume(bkhc_pkg::BKHC_GO_RESET);
      wr(`BKHC_OFS_CTRL, 32'h2);
      rd(`BKHC_OFS_CTRL, v);
      chk("shadowrun", v, 32'h0);
      rst(1'b1);
      // suspend: refused in user mode until permitted
      user_mode <= 1'b1;
      pulse(4'h2);
      chk("priv", 32'(priv_violation), 32'h1);
      chk("nohalt", 32'(core_halted), 32'h0);
      wr(`BKHC_OFS_CTRL, 32'h1);
      pulse(4'h2);
      halted(`BKHC_SRC_SUSPEND);
      resume(bkhc_pkg::BKHC_GO_NEXT);
      user_mode <= 1'b0;
      pulse(4'h1);
      halted(`BKHC_SRC_FAULT);
      resume(2'h3);
      pulse(4'h3);
      halted(`BKHC_SRC_FAULT);
      resume(2'h3);
      // pin while running, then pin during sleep
      breakpoint_request_n <= 1'b0;
      halted(`BKHC_SRC_PIN);
      breakpoint_request_n <= 1'b1;
      repeat (3) @(posedge mclk);
      resume(2'h3);
      pulse(4'h8);
      chk("stopped", 32'(core_stopped), 32'h1);
      breakpoint_request_n <= 1'b0;
      halted(`BKHC_SRC_SLEEP);
      breakpoint_request_n <= 1'b1;
      repeat (3) @(posedge mclk);
      resume(bkhc_pkg::BKHC_GO_NEXT);
      // report-only trigger conditions
      wr(`BKHC_OFS_ADDR_LO, 32'h0000_0100);
      wr(`BKHC_OFS_ADDR_HI, 32'h0000_01FF);
      wr(`BKHC_OFS_PC_VAL, 32'h0000_2000);
      wr(`BKHC_OFS_PC_MASK, 32'h0000_000F);
      wr(`BKHC_OFS_DATA_VAL, 32'h1234_5678);
      foreach (tab[i])
      begin
         wr(`BKHC_OFS_TRIG, {16'h0, tab[i][47:32]});
         acc(tab[i][31:0]);
         chk("hit", 32'(h), 32'(tab[i][48]));
      end
      // two levels: the second completes only once the first has armed
      wr(`BKHC_OFS_TRIG, 32'h3000_2004);
      rd(`BKHC_OFS_TRIG, v);
      chk("trig", v, 32'h3000_2004);
      acc(32'h1234_5678);
      chk("unarmed", 32'(h), 32'h0);
      acc(32'h0000_0100);
      chk("armonly", 32'(h), 32'h0);
      acc(32'h1234_5678);
      chk("second", 32'(h), 32'h1);
      chk("ddlvl2", 32'(o), 32'h8);
      // halt and interrupt responses
      wr(`BKHC_OFS_TRIG, 32'h0000_7000);
      acc(32'h1234_5678);
      halted(`BKHC_SRC_BRKPT);
      wr(`BKHC_OFS_TRIG, 32'h0);
      resume(2'h3);
      wr(`BKHC_OFS_TRIG, 32'h0000_B000);
      acc(32'h1234_5678);
      chk("irq", 32'(q), 32'h1);
      chk("ddirq", 32'(o), 32'h6);
      chk("irqhalt", 32'(core_halted), 32'h0);
      wrap_up();
   end
endmodule // bkhc_top_tb_top

bind bkhc_top bkhc_assertions bkhc_assertions_i (.mclk, .srst, .fault_on_fault,
   .suspend_exec, .sample_point, .user_mode, .resume_command, .breakpoint_request_n,
   .core_halted, .core_stopped, .priv_violation, .debug_irq, .trig_report,
   .reset_exc_start, .resume_pulse, .processor_status_outputs, .debug_data_outputs);

`default_nettype wire
